/* File: hw/agd_pkg.sv */
package agd_pkg;
  // register word indices
  localparam logic [0:0] CLR_IDX = 1'h0;
  localparam logic [0:0] SET_IDX = 1'h1;
  localparam int PERIPH_COUNT = 32;
  localparam logic [31:0] PROT_RESET = 32'h00000000;
  localparam logic [3:0] BE_NONE = 4'h0;
  // byte lanes of a register word
  localparam int BE_WIDTH = 4;
  localparam int BYTE_BITS = 8;

  // request from the bus side
  typedef struct packed {
    logic valid;
    logic write;
    logic debug;
    logic [7:0] target;
    logic [3:0] be;
    logic [31:0] wdata;
  } agd_req_t;

  // access into the protection registers themselves
  typedef struct packed {
    logic valid;
    logic write;
    logic addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } agd_reg_t;
endpackage

/* File: hw/agd_access_guard.sv */
`timescale 1ns/1ps
// How it works
// RULE_01: one guard per bridge, covering every peripheral behind that bridge.
// RULE_02: bus clock is gated outside; instance reset-on state is a parameter.
// RULE_03: keeps working whenever its clock runs, including sleep modes.
// RULE_04: debugger writes bypass protection and always pass through.
// RULE_05: one in clear register clears that protection bit.
// RULE_06: one in set register sets that protection bit.
// RULE_07: both registers read back the same protection vector.
// RULE_08: non-debug write to protected peripheral is blocked with an error.
// RULE_09: setting an already set bit returns an error.
// RULE_10: clearing an already clear bit returns an error.
// RULE_11: software must serialise protection changes or read the set register first.
// RULE_12: byte, half-word and word accesses supported via byte enables.
// RULE_13: zero bits written leave protection unchanged.
// RULE_14: a rejected double set or clear changes nothing.
module agd_access_guard #(
  parameter int N_PERIPH = agd_pkg::PERIPH_COUNT,
  parameter bit CLOCK_ON_AT_RESET = 1'b1
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // peripheral write check
  input wire agd_pkg::agd_req_t req_i,
  output logic grant_o,
  output logic block_o,
  output logic done_o,
  // protection register access
  input wire agd_pkg::agd_reg_t reg_i,
  output logic [31:0] reg_rdata_o,
  output logic reg_err_o,
  output logic reg_done_o,
  // state
  output logic [N_PERIPH-1:0] prot_o,
  output logic clk_en_default_o
);
  logic [N_PERIPH-1:0] prot;
  logic [31:0] wmask;
  logic [N_PERIPH-1:0] hit;
  logic dbl;
  logic wr_ok;

  // byte enables into a bit mask
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < agd_pkg::BE_WIDTH; i++) begin
      m[i*agd_pkg::BYTE_BITS +: agd_pkg::BYTE_BITS] = {agd_pkg::BYTE_BITS{be[i]}};
    end
    return m;
  endfunction

  // protection vector after an accepted set or clear write
  function automatic logic [N_PERIPH-1:0] next_vec(input logic set_sel, input logic [N_PERIPH-1:0] cur,
                                                   input logic [N_PERIPH-1:0] hits);
    if (set_sel) begin
      return cur | hits; // [RULE_06]
    end else begin
      return cur & ~hits; // [RULE_05]
    end
  endfunction

  // effective written ones, sized to peripheral count
  always_comb begin
    wmask = reg_i.wdata & be_mask(reg_i.be); // [RULE_12]
    hit = wmask[N_PERIPH-1:0]; // [RULE_13]
    if (reg_i.addr == agd_pkg::SET_IDX) begin
      dbl = |(hit & prot); // [RULE_09]
    end else begin
      dbl = |(hit & ~prot); // [RULE_10]
    end
    wr_ok = reg_i.valid && reg_i.write && (reg_i.be != agd_pkg::BE_NONE) && !dbl;
  end

  // protection vector update
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      prot <= agd_pkg::PROT_RESET[N_PERIPH-1:0];
    end else if (wr_ok) begin // [RULE_14]
      prot <= next_vec(reg_i.addr == agd_pkg::SET_IDX, prot, hit); // [RULE_05] [RULE_06]
    end
  end

  // register answer
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= '0;
      reg_err_o <= 1'b0;
      reg_done_o <= 1'b0;
    end else begin
      reg_done_o <= reg_i.valid;
      reg_err_o <= reg_i.valid && reg_i.write && dbl; // [RULE_09] [RULE_10]
      reg_rdata_o <= '0;
      if (reg_i.valid && !reg_i.write) begin
        reg_rdata_o[N_PERIPH-1:0] <= prot; // [RULE_07]
      end
    end
  end

  // peripheral write gate, one result per request
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      grant_o <= 1'b0;
      block_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= req_i.valid;
      if (req_i.valid && req_i.write && !req_i.debug && 32'(req_i.target) < N_PERIPH
          && prot[req_i.target[$clog2(N_PERIPH)-1:0]]) begin
        grant_o <= 1'b0;
        block_o <= 1'b1; // [RULE_08] [RULE_01]
      end else begin
        grant_o <= req_i.valid; // [RULE_04]
        block_o <= 1'b0;
      end
    end
  end

  // state outputs
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      prot_o <= agd_pkg::PROT_RESET[N_PERIPH-1:0];
      clk_en_default_o <= CLOCK_ON_AT_RESET; // [RULE_02] [RULE_03]
    end else begin
      prot_o <= wr_ok ? next_vec(reg_i.addr == agd_pkg::SET_IDX, prot, hit) : prot;
      clk_en_default_o <= CLOCK_ON_AT_RESET;
    end
  end
endmodule

/* File: verif/agd_chk_assertions.sv */
`timescale 1ns/1ps
// port checks on the guard
module agd_chk #(parameter int N_PERIPH = 32) (
  input wire logic ref_clk_i, sys_rst_i, grant_o, block_o, done_o, reg_err_o, reg_done_o,
  input wire agd_pkg::agd_req_t req_i,
  input wire agd_pkg::agd_reg_t reg_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [N_PERIPH-1:0] prot_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // full-word write and the bits it collides with
  wire wr = reg_i.valid & reg_i.write & reg_i.be == 4'hF;
  wire [31:0] hit = reg_i.wdata & (reg_i.addr ? prot_o : ~prot_o);
  a_req_answer: assert property (req_i.valid |=> done_o) else $error("late");
  a_dbg_pass: assert property (req_i.valid & req_i.debug |=> grant_o) else $error("dbg");
  a_prot_block: assert property (req_i.valid & req_i.write & !req_i.debug & (req_i.target < N_PERIPH) & prot_o[req_i.target] |=> block_o)
    else $error("blk");
  a_reg_answer: assert property (reg_i.valid |=> reg_done_o) else $error("late");
  a_double_err: assert property (wr & |hit |=> reg_err_o & $stable(prot_o)) else $error("dbl");
  a_set_apply: assert property (wr & reg_i.addr & !hit |=> prot_o == ($past(prot_o) | $past(reg_i.wdata)))
    else $error("set");
  a_clr_apply: assert property (wr & !reg_i.addr & !hit |=> prot_o == ($past(prot_o) & ~$past(reg_i.wdata)))
    else $error("clr");
  a_read_same: assert property (reg_i.valid & !reg_i.write |=> reg_rdata_o == $past(prot_o)) else $error("rd");
  c_blk: cover property (block_o);
  c_err: cover property (reg_err_o);
  c_grant: cover property (grant_o);
endmodule
bind agd_access_guard agd_chk #(.N_PERIPH(N_PERIPH)) i_chk (.*);

/* File: verif/agd_host.sv */
`timescale 1ns/1ps
// initiator: one full-word write per strobe, data repeats the target byte in every lane
module agd_host (input wire logic clk_i, go_i, dbg_i, input wire logic [7:0] tgt_i, output agd_pkg::agd_req_t req_o);
  always_ff @(posedge clk_i) req_o <= {go_i, 1'b1, dbg_i, tgt_i, 4'hF, {4{tgt_i}}};
endmodule

/* File: verif/agd_access_guard_tb.sv */
`timescale 1ns/1ps
// bench for the guard
module agd_access_guard_tb;
  logic ref_clk_i = 0, sys_rst_i = 1, go = 0, dbg = 0, grant_o, block_o, done_o, reg_err_o, reg_done_o, ce;
  logic [7:0] tgt = 0;
  logic [31:0] reg_rdata_o, prot_o;
  agd_pkg::agd_reg_t reg_i = '0;
  agd_pkg::agd_req_t req;
  int err_count = 0, comparisons = 0;
  // clock and both sides
  always #4 ref_clk_i = ~ref_clk_i;
  agd_host i_host (.clk_i(ref_clk_i), .go_i(go), .dbg_i(dbg), .tgt_i(tgt), .req_o(req));
  agd_access_guard i_dut (.ref_clk_i, .sys_rst_i, .req_i(req), .grant_o, .block_o, .done_o, .reg_i, .reg_rdata_o,
    .reg_err_o, .reg_done_o, .prot_o, .clk_en_default_o(ce));
  task chk(string n, logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask
  // register access, answer sampled in its one cycle
  task rg(logic w, a, logic [3:0] be, logic [31:0] d, p, logic r);
    @(posedge ref_clk_i) reg_i <= {1'b1, w, a, be, d};
    @(posedge ref_clk_i) reg_i.valid <= 0;
    #1 chk("prot", p, prot_o);
    chk("err", r, reg_err_o);
    chk("reg_done", 1, reg_done_o);
    if (!w) chk("rdata", p, reg_rdata_o);
    $display("register test done");
  endtask
  // reset in mid-run returns the vector to its reset value
  task rst;
    @(posedge ref_clk_i) sys_rst_i <= 1;
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 0;
    #1 chk("prot_rst", 0, prot_o);
    chk("block_rst", 0, block_o);
    $display("reset test done");
  endtask
  // peripheral write via the initiator
  task pw(logic d, logic [7:0] t, logic b);
    @(posedge ref_clk_i) {go, dbg, tgt} <= {1'b1, d, t};
    @(posedge ref_clk_i) go <= 0;
    @(posedge ref_clk_i) #1 chk("block", b, block_o);
    chk("grant", !b, grant_o);
    chk("done", 1, done_o);
    $display("peripheral test done");
  endtask
  task finish_test;
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge ref_clk_i);
    sys_rst_i <= 0;
    #1 chk("clk_en", 1, ce);
    rg(1, 1, 4'hF, 32'h8, 32'h8, 0);
    rg(0, 0, 4'hF, 0, 32'h8, 0);
    rg(0, 1, 4'hF, 0, 32'h8, 0);
    rg(1, 1, 4'hF, 32'h8, 32'h8, 1);
    rg(1, 1, 4'hF, 0, 32'h8, 0);
    rg(1, 1, 4'h2, 32'h100, 32'h108, 0);
    pw(0, 3, 1);
    pw(0, 4, 0);
    pw(1, 3, 0);
    rg(1, 0, 4'hF, 32'h108, 0, 0);
    rg(1, 0, 4'hF, 32'h8, 0, 1);
    pw(0, 3, 0);
    rg(1, 1, 4'hF, 32'h8, 32'h8, 0);
    rst();
    pw(0, 3, 0);
    $display("scenarios done");
    finish_test();
  end
endmodule
